// [vic_consts.svh]
// Constants for the vectored interrupt controller.
// Assumes inclusion by vic_pkg.sv and vic_top.sv only.
`ifndef VIC_CONSTS_SVH
`define VIC_CONSTS_SVH
`define VIC_NUM_SRC 18
`define VIC_VEC_BASE 16'h0003
`define VIC_VEC_STEP 16'h0008
`define VIC_ADDR_EN_A 8'ha8
`define VIC_ADDR_EN_B 8'hb8
`define VIC_ADDR_EN_C 8'h9a
`define VIC_ADDR_FLAG_A 8'h88
`define VIC_ADDR_FLAG_B 8'hc0
`define VIC_ADDR_FLAG_C 8'he8
`define VIC_ADDR_PRIO_LO 8'ha9
`define VIC_ADDR_PRIO_HI 8'hb9
`define VIC_ADDR_STAT 8'hd0
`define VIC_ADDR_MASK 8'hd1
`define VIC_ADDR_SUBMASK 8'hd2
`define VIC_GEN_BIT 7
`define VIC_RESET_BYTE 8'h00
`define VIC_DETECT_CYC 1
`define VIC_CALL_CYC 6
`define VIC_NUM_GRP 6
`endif

// [vic_pkg.sv]
// Types for the vectored interrupt controller.
// Assumes vic_consts.svh in the include path.
`include "vic_consts.svh"
package vic_pkg;
  typedef logic [`VIC_NUM_SRC-1:0] vic_vec_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } vic_bus_t;
  typedef struct packed {
    logic req;
    logic [4:0] num;
    logic [15:0] addr;
    logic [1:0] lvl;
  } vic_call_t;
  typedef enum logic [1:0] {VIC_IDLE, VIC_DETECT, VIC_CALL} vic_state_t;
endpackage : vic_pkg

// [vic_top.sv]
// Vectored interrupt controller with priority groups and nesting.
// Assumes sources and core on i_clk; events are one-cycle pulses.
//
// Operation
// - Eighteen sources, each with own flag.
// - Per-source enable bits across three registers.
// - Source groups get software-selected priority levels.
// - Multi-event peripherals get per-event mask bits.
// - Global enable gates every acknowledge.
// - Vector address is eight times n plus three.
// - Source 0 radio fifo error, vector 03h.
// - Source 1 converter done, vector 0Bh.
// - Source 9 wide timer, vector 4Bh.
// - Source 11 narrow timer a, 5Bh.
// - Source 12 narrow timer b, 63h.
// - Source 17 watchdog timer mode, 8Bh.
// - Flags set regardless of enable state.
// - Enabled flag forces long call; higher preempts.
// - Response is one detect plus six call.
// - Equal or lower priority waits pending.
//
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "vic_consts.svh"
module vic_top (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic [`VIC_NUM_SRC-1:0] i_event,
  input wire logic [7:0] i_sub_event,
  input wire logic i_return_from_irq,
  output logic o_long_call,
  output logic [15:0] o_vector,
  output logic [4:0] o_irq_num,
  output logic o_irq
);
  localparam int NS = `VIC_NUM_SRC;
  localparam int CALL_CYC = `VIC_CALL_CYC;

  vic_pkg::vic_bus_t bus;
  assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  function automatic logic [15:0] vec_of(input logic [4:0] n);
    vec_of = `VIC_VEC_BASE + (`VIC_VEC_STEP * {11'h000, n});
  endfunction : vec_of

  // Group of each source: n mod 6
  function automatic logic [2:0] grp_of(input int n);
    grp_of = 3'(n % `VIC_NUM_GRP);
  endfunction : grp_of

  ////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] en_a_q, en_b_q, en_c_q, prio_lo_q, prio_hi_q, mask_q, submask_q;
  logic [7:0] stat_q, rdata_q;
  vic_pkg::vic_vec_t flag_q;
  logic [7:0] sub_hit;
  logic [4:0] sub_or;

  // Source bit positions in the enable registers
  vic_pkg::vic_vec_t en_map;
  always_comb begin
    en_map = '0;
    en_map[5:0] = en_a_q[5:0];
    en_map[6] = en_c_q[1];
    en_map[7] = en_c_q[2];
    en_map[8] = en_b_q[0];
    en_map[12:9] = en_b_q[4:1];
    en_map[13] = en_b_q[5];
    en_map[14] = en_c_q[3];
    en_map[15] = en_c_q[4];
    en_map[16] = en_c_q[0];
    en_map[17] = en_c_q[5];
  end

  // Peripheral sub-events gated by own masks
  assign sub_hit = i_sub_event & submask_q;
  assign sub_or = {|sub_hit[7:6], |sub_hit[5:4], |sub_hit[3:2], sub_hit[1], sub_hit[0]};
  vic_pkg::vic_vec_t ev;
  always_comb begin
    ev = i_event;
    ev[13] = i_event[13] | sub_or[0];
    ev[15] = i_event[15] | sub_or[1];
    ev[6] = i_event[6] | sub_or[2];
    ev[8] = i_event[8] | sub_or[3];
    ev[16] = i_event[16] | sub_or[4];
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      en_a_q <= `VIC_RESET_BYTE;
      en_b_q <= `VIC_RESET_BYTE;
      en_c_q <= `VIC_RESET_BYTE;
      prio_lo_q <= `VIC_RESET_BYTE;
      prio_hi_q <= `VIC_RESET_BYTE;
      mask_q <= `VIC_RESET_BYTE;
      submask_q <= `VIC_RESET_BYTE;
    end else if (bus.wr) begin
      case (bus.addr)
        `VIC_ADDR_EN_A: en_a_q <= bus.wdata & 8'hbf;
        `VIC_ADDR_EN_B: en_b_q <= bus.wdata & 8'h3f;
        `VIC_ADDR_EN_C: en_c_q <= bus.wdata & 8'h3f;
        `VIC_ADDR_PRIO_LO: prio_lo_q <= bus.wdata & 8'h3f;
        `VIC_ADDR_PRIO_HI: prio_hi_q <= bus.wdata & 8'h3f;
        `VIC_ADDR_MASK: mask_q <= bus.wdata & 8'h07;
        `VIC_ADDR_SUBMASK: submask_q <= bus.wdata;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////
  // Flags: set wins over clear, set regardless of enable
  logic ack;
  logic [4:0] sel_num;
  vic_pkg::vic_vec_t wr_clr;
  always_comb begin
    wr_clr = '0;
    if (bus.wr) begin
      case (bus.addr)
        `VIC_ADDR_FLAG_A: wr_clr[7:0] = ~bus.wdata;
        `VIC_ADDR_FLAG_B: wr_clr[15:8] = ~bus.wdata;
        `VIC_ADDR_FLAG_C: wr_clr[17:16] = ~bus.wdata[1:0];
        default: ;
      endcase
    end
    if (ack) begin
      wr_clr[sel_num] = 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      flag_q <= '0;
    end else begin
      flag_q <= (flag_q & ~wr_clr) | ev;
    end
  end

  ////////////////////////////////////////////////////////////
  // Priority resolve
  logic [1:0] lvl [NS];
  logic [3:0] act_q;
  vic_pkg::vic_vec_t live;
  logic found;
  logic [1:0] sel_lvl;
  always_comb begin
    for (int n = 0; n < NS; n++) begin
      lvl[n] = {prio_hi_q[grp_of(n)], prio_lo_q[grp_of(n)]};
    end
  end
  assign live = flag_q & en_map & {NS{en_a_q[`VIC_GEN_BIT]}};

  always_comb begin
    found = 1'b0;
    sel_num = '0;
    sel_lvl = '0;
    for (int l = 3; l >= 0; l--) begin
      for (int n = 0; n < NS; n++) begin
        if (!found && live[n] && lvl[n] == 2'(l)) begin
          found = 1'b1;
          sel_num = 5'(n);
          sel_lvl = 2'(l);
        end
      end
    end
  end

  // Highest active level, or none
  logic act_any;
  logic [1:0] act_top;
  always_comb begin
    act_any = |act_q;
    act_top = 2'h0;
    for (int l = 0; l < 4; l++) begin
      if (act_q[l]) begin
        act_top = 2'(l);
      end
    end
  end
  logic can_take;
  assign can_take = found && (!act_any || sel_lvl > act_top);

  ////////////////////////////////////////////////////////////
  // Detect and call sequence
  vic_pkg::vic_state_t st_q;
  logic [2:0] cnt_q;
  vic_pkg::vic_call_t call_q;
  assign ack = (st_q == vic_pkg::VIC_IDLE) && can_take;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_q <= vic_pkg::VIC_IDLE;
      cnt_q <= '0;
      call_q <= '0;
    end else begin
      case (st_q)
        vic_pkg::VIC_IDLE: begin
          call_q.req <= 1'b0;
          if (ack) begin
            st_q <= vic_pkg::VIC_DETECT;
            call_q.num <= sel_num;
            call_q.addr <= vec_of(sel_num);
            call_q.lvl <= sel_lvl;
          end
        end
        vic_pkg::VIC_DETECT: begin
          st_q <= vic_pkg::VIC_CALL;
          cnt_q <= 3'(CALL_CYC - 1);
          call_q.req <= 1'b1;
        end
        vic_pkg::VIC_CALL: begin
          if (cnt_q == 3'h0) begin
            st_q <= vic_pkg::VIC_IDLE;
            call_q.req <= 1'b0;
          end else begin
            cnt_q <= cnt_q - 3'h1;
          end
        end
        default: st_q <= vic_pkg::VIC_IDLE;
      endcase
    end
  end

  // Nesting stack of active levels
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      act_q <= '0;
    end else begin
      if (i_return_from_irq && act_any) begin
        act_q[act_top] <= 1'b0;
      end
      if (st_q == vic_pkg::VIC_DETECT) begin
        act_q[call_q.lvl] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // Status: sticky bits for return (bit 0), call start (bit 1) and a flag pending on a disabled source (bit 2); a read clears them
  logic rd_stat;
  logic [7:0] stat_set;
  assign rd_stat = bus.rd && bus.addr == `VIC_ADDR_STAT;
  assign stat_set = {6'h00, (st_q == vic_pkg::VIC_DETECT), (i_return_from_irq && act_any)}
                    | {5'h00, |(flag_q & ~en_map), 2'h0};
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      stat_q <= '0;
    end else begin
      stat_q <= (rd_stat ? 8'h00 : stat_q) | stat_set;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_q <= '0;
    end else if (bus.rd) begin
      case (bus.addr)
        `VIC_ADDR_EN_A: rdata_q <= en_a_q;
        `VIC_ADDR_EN_B: rdata_q <= en_b_q;
        `VIC_ADDR_EN_C: rdata_q <= en_c_q;
        `VIC_ADDR_FLAG_A: rdata_q <= flag_q[7:0];
        `VIC_ADDR_FLAG_B: rdata_q <= flag_q[15:8];
        `VIC_ADDR_FLAG_C: rdata_q <= {6'h00, flag_q[17:16]};
        `VIC_ADDR_PRIO_LO: rdata_q <= prio_lo_q;
        `VIC_ADDR_PRIO_HI: rdata_q <= prio_hi_q;
        `VIC_ADDR_STAT: rdata_q <= stat_q;
        `VIC_ADDR_MASK: rdata_q <= mask_q;
        `VIC_ADDR_SUBMASK: rdata_q <= submask_q;
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign o_rdata = rdata_q;
  assign o_long_call = call_q.req;
  assign o_vector = call_q.addr;
  assign o_irq_num = call_q.num;
  assign o_irq = |(stat_q & mask_q);

  ////////////////////////////////////////////////////////////
  // Checks

  property p_vec;
    @(posedge i_clk) disable iff (i_rst)
    o_long_call |-> o_vector == 16'(8 * o_irq_num + 3);
  endproperty
  a_vec: assert property (p_vec) else $error("vector not 8n+3");

  property p_gen;
    @(posedge i_clk) disable iff (i_rst)
    ack |-> en_a_q[7];
  endproperty
  a_gen: assert property (p_gen) else $error("ack without global enable");

  property p_en;
    @(posedge i_clk) disable iff (i_rst)
    ack |-> en_map[sel_num] && flag_q[sel_num];
  endproperty
  a_en: assert property (p_en) else $error("ack of disabled source");

  property p_resp;
    @(posedge i_clk) disable iff (i_rst)
    ack |=> !o_long_call ##1 o_long_call [*6] ##1 !o_long_call;
  endproperty
  a_resp: assert property (p_resp) else $error("response not 1+6 cycles");

  property p_flag;
    @(posedge i_clk) disable iff (i_rst)
    i_event[1] |=> flag_q[1];
  endproperty
  a_flag: assert property (p_flag) else $error("flag not set by event");

  property p_pend;
    @(posedge i_clk) disable iff (i_rst)
    ack && act_any |-> sel_lvl > act_top;
  endproperty
  a_pend: assert property (p_pend) else $error("equal level preempted");

  property p_low;
    @(posedge i_clk) disable iff (i_rst)
    ack && live[0] && lvl[0] == sel_lvl |-> sel_num == 5'h00;
  endproperty
  a_low: assert property (p_low) else $error("lower number not first");

  property p_ret;
    @(posedge i_clk) disable iff (i_rst)
    i_return_from_irq && act_any && st_q != vic_pkg::VIC_DETECT |=> !act_q[$past(act_top)];
  endproperty
  a_ret: assert property (p_ret) else $error("level not released on return");

  property p_wd;
    @(posedge i_clk) disable iff (i_rst)
    o_long_call && o_irq_num == 5'd17 |-> o_vector == 16'h008b;
  endproperty
  a_wd: assert property (p_wd) else $error("watchdog vector wrong");
endmodule : vic_top

// [vic_core_model.sv]
// Core model: answers a finished forced call with a return.
// Assumes the controller's clock; the bench asks for each return.
`timescale 1ns/1ps
module vic_core_model (
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic i_long_call,
  output logic o_ret
);
  logic pend_q = 1'b0;
  initial o_ret = 1'b0;
  // Return only once the forced call is over
  always @(posedge i_clk) begin
    o_ret <= pend_q && !i_long_call;
    if (i_go) begin
      pend_q <= 1'b1;
    end else if (!i_long_call) begin
      pend_q <= 1'b0;
    end
  end
endmodule : vic_core_model

// [testbench.sv]
// Self-checking bench for the interrupt controller.
// Assumes vic_top and vic_core_model on one 200 MHz clock.
`timescale 1ns/1ps
module testbench;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [17:0] i_event = '0;
  logic [7:0] i_sub_event = 8'h00;
  logic ret_go = 1'b0;
  logic i_return_from_irq, o_long_call, o_irq;
  logic [7:0] o_rdata, rv;
  logic [15:0] o_vector;
  logic [4:0] o_irq_num;
  logic [7:0] ra [12] = '{8'ha8, 8'hb8, 8'h9a, 8'h88, 8'hc0, 8'he8, 8'ha9, 8'hb9, 8'hd0, 8'hd1, 8'hd2, 8'h55};
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;
  always #2.5 i_clk = ~i_clk;
  vic_top dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_event(i_event), .i_sub_event(i_sub_event),
    .i_return_from_irq(i_return_from_irq), .o_long_call(o_long_call), .o_vector(o_vector),
    .o_irq_num(o_irq_num), .o_irq(o_irq));
  vic_core_model core_u (.i_clk(i_clk), .i_go(ret_go), .i_long_call(o_long_call), .o_ret(i_return_from_irq));
  ////////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (n_fail == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      stop_test();
    end
  end
  task automatic chk(input string nm, input int e, input logic [15:0] g);
    num_checks++;
    if (g !== e[15:0]) begin
      n_fail++;
      $display("BAD %s exp %0h got %0h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 rv = o_rdata;
  endtask : rd
  task automatic pulse(input logic [17:0] e, input logic [7:0] s);
    @(posedge i_clk);
    i_event <= e;
    i_sub_event <= s;
    @(posedge i_clk);
    i_event <= '0;
    i_sub_event <= 8'h00;
  endtask : pulse
  task automatic flags(input logic [17:0] f);
    rd(8'h88);
    chk("flag_a", f[7:0], rv);
    rd(8'hc0);
    chk("flag_b", f[15:8], rv);
    rd(8'he8);
    chk("flag_c", f[17:16], rv);
  endtask : flags
  task automatic set_en(input logic [17:0] m, input logic g);
    wr(8'h88, 8'h00);
    wr(8'hc0, 8'h00);
    wr(8'he8, 8'h00);
    wr(8'ha8, {g, 7'h00});
    wr(8'ha8, {g, 1'b0, m[5:0]});
    wr(8'hb8, {2'b00, m[13], m[12:9], m[8]});
    wr(8'h9a, {2'b00, m[17], m[15], m[14], m[7], m[6], m[16]});
  endtask : set_en
  task automatic take(input int n);
    int k;
    k = 0;
    do begin
      @(posedge i_clk);
      #1 k++;
    end while (o_long_call !== 1'b1 && k < 30);
    chk("vector", 8 * n + 3, o_vector);
    chk("irq_num", n, o_irq_num);
    k = 0;
    while (o_long_call === 1'b1 && k < 20) begin
      @(posedge i_clk);
      #1 k++;
    end
    chk("call_len", 6, k);
  endtask : take
  task automatic none();
    int k;
    k = 0;
    repeat (20) begin
      @(posedge i_clk);
      #1 if (o_long_call !== 1'b0) k++;
    end
    chk("no_call", 0, k);
  endtask : none
  task automatic ret();
    @(posedge i_clk);
    ret_go <= 1'b1;
    @(posedge i_clk);
    ret_go <= 1'b0;
    @(posedge i_clk);
  endtask : ret
  ////////////////////////////////////////////////////////////////
  initial begin
    logic [17:0] fm;
    logic [7:0] s, sm;
    void'($urandom(90));
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    foreach (ra[i]) begin
      rd(ra[i]);
      chk("reset", 0, rv);
    end
    wr(8'ha8, 8'hff);
    rd(8'ha8);
    chk("en_a", 8'hbf, rv);
    wr(8'hb8, 8'hff);
    rd(8'hb8);
    chk("en_b", 8'h3f, rv);
    set_en(18'h0, 1'b0);
    pulse(18'h3ffff, 8'h00);
    flags(18'h3ffff);
    repeat (4) begin
      sm = 8'($urandom);
      s = 8'($urandom);
      set_en(18'h0, 1'b0);
      wr(8'hd2, sm);
      pulse(18'h0, s);
      fm = '0;
      fm[13] = s[0] & sm[0];
      fm[15] = s[1] & sm[1];
      fm[6] = |(s[3:2] & sm[3:2]);
      fm[8] = |(s[5:4] & sm[5:4]);
      fm[16] = |(s[7:6] & sm[7:6]);
      flags(fm);
    end
    wr(8'hd2, 8'h00);
    for (int n = 0; n < 18; n++) begin
      set_en(18'h1 << n, 1'b1);
      pulse(18'h1 << n, 8'h00);
      take(n);
      flags(18'h0);
      ret();
    end
    set_en(18'h20000, 1'b0);
    pulse(18'h20000, 8'h00);
    none();
    flags(18'h20000);
    wr(8'ha8, 8'h80);
    take(17);
    ret();
    set_en(18'h0000a, 1'b0);
    pulse(18'h0000a, 8'h00);
    wr(8'ha8, 8'h8a);
    take(1);
    ret();
    take(3);
    ret();
    wr(8'ha9, 8'h04);
    wr(8'hb9, 8'h04);
    set_en(18'h6, 1'b1);
    pulse(18'h2, 8'h00);
    take(1);
    pulse(18'h4, 8'h00);
    take(2);
    pulse(18'h2, 8'h00);
    none();
    ret();
    none();
    ret();
    take(1);
    ret();
    wr(8'hd1, 8'h02);
    @(posedge i_clk);
    #1 chk("irq_hi", 1, o_irq);
    rd(8'hd0);
    chk("status", 8'h07, rv);
    @(posedge i_clk);
    #1 chk("irq_lo", 0, o_irq);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(8'hd1);
    chk("mask_rst", 0, rv);
    stop_test();
  end
endmodule : testbench
